// >>> design/timer_pkg.sv
// package: register map, field positions, reset values, codes for the timer
package timer_pkg;
  localparam logic [7:0]  channel_mode_addr      = 8'h18;
  localparam logic [7:0]  channel_enable_polarity_addr = 8'h20;
  localparam logic [7:0]  counter_value_addr     = 8'h24;
  localparam logic [7:0]  clock_divider_addr     = 8'h28;
  localparam logic [7:0]  reload_limit_addr      = 8'h2c;
  localparam logic [7:0]  channel_one_compare_addr = 8'h34;
  localparam logic [7:0]  channel_two_compare_addr = 8'h38;
  localparam logic [7:0]  run_control_addr       = 8'h00;
  // enable/polarity register: live bits, all others reserved zero
  localparam logic [15:0] enable_polarity_mask   = 16'h00bb;
  localparam int          ch1_enable_bit         = 0;
  localparam int          ch1_polarity_bit       = 1;
  localparam int          ch1_comp_polarity_bit  = 3;
  localparam int          ch2_enable_bit         = 4;
  localparam int          ch2_polarity_bit       = 5;
  localparam int          ch2_comp_polarity_bit  = 7;
  // channel mode register fields (channel n at offset 8*n)
  localparam int          direction_lsb          = 0;
  localparam int          event_div_lsb          = 2;
  localparam int          preload_bit            = 3;
  localparam int          compare_mode_lsb       = 4;
  localparam int          channel_field_step     = 8;
  localparam logic [15:0] channel_mode_mask      = 16'h7f7f;
  localparam logic [1:0]  direction_output       = 2'h0;
  localparam logic [1:0]  direction_own_pin      = 2'h1;
  localparam logic [1:0]  direction_other_pin    = 2'h2;
  localparam logic [15:0] reg_reset              = 16'h0000;
  localparam int          run_bit                = 0;
  localparam logic [1:0]  axi_okay               = 2'h0;
  localparam logic [1:0]  axi_slverr             = 2'h2;
  typedef enum logic [2:0] {
    mode_frozen   = 3'b000,
    mode_set      = 3'b001,
    mode_clear    = 3'b010,
    mode_toggle   = 3'b011,
    mode_force_lo = 3'b100,
    mode_force_hi = 3'b101,
    mode_pwm1     = 3'b110,
    mode_pwm2     = 3'b111
  } compare_mode_type;
endpackage

// >>> design/two_channel_timer_compare_core.sv
// two-channel timer: counter, prescaler, capture/compare, axi4-lite slave
//
// Behaviour
// - output polarity 0 active high, 1 active low
// - input pair 00 rising, 01 falling inverted
// - input pair 11 reacts on both edges
// - enable clear forces output and drive enable low
// - input enable gates capture into compare register
// - channel two bits 7,5,4 mirror channel one
// - reserved enable-register bits stay zero
// - counter readable and writable, reset zero
// - counter rate is input clock over divider+1
// - divider write takes effect at update event
// - reload register holds the counting period
// - counter stops while reload limit is zero
// - compare preload off immediate, on at update
// - active compare drives output reference continuously
// - channel one compare holds last capture one
// - channel two compare holds last capture two
// - every register reachable as 16-bit location
// - direction field writable only while channel disabled
// - capture event divider resets when enable cleared
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module two_channel_timer_compare_core
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // axi4-lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // channel pins
  input  wire logic [1:0]  capture_pin,
  output logic             ch1_output,
  output logic             ch2_output,
  output logic [1:0]       output_drive_enable
);

  // all state of the core in one record
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [15:0] run_control;
    logic [15:0] channel_mode;
    logic [15:0] enable_polarity;
    logic [15:0] count;
    logic [15:0] divider_shadow;
    logic [15:0] divider_active;
    logic [15:0] divider_count;
    logic [15:0] reload_limit;
    logic [1:0][15:0] compare_shadow;
    logic [1:0][15:0] compare_active;
    logic [1:0][2:0]  event_count;
    logic [1:0]  reference;
    logic [1:0]  pin_out;
    logic [1:0]  pin_oe;
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic [1:0]  sync3;
    logic [1:0]  settled;
  } state_type;

  state_type state;
  state_type next_state;

  // capture events per capture minus one (0, 1, 3, 7), from the event divider field
  function automatic logic [2:0] events_per_capture(input logic [1:0] code);
    unique case (code)
      2'h0: events_per_capture = 3'h0;
      2'h1: events_per_capture = 3'h1;
      2'h2: events_per_capture = 3'h3;
      2'h3: events_per_capture = 3'h7;
    endcase
  endfunction

  // 16-bit lane write with byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction

  logic        wr_go;
  logic        rd_go;
  logic        update_event;
  logic        count_tick;
  logic        run;
  logic [15:0] wr_value;
  logic [1:0]  dir [2];
  logic [1:0]  enable;
  logic [1:0]  polarity;
  logic [1:0]  comp_polarity;
  logic [1:0]  source;
  logic [1:0]  rise;
  logic [1:0]  fall;
  logic [1:0]  edge_hit;
  logic [1:0]  capture_now;
  logic [1:0]  ch_is_input;
  logic [15:0] mode_new;

  always_comb begin
    next_state = state;
    wr_go = state.aw_held && state.w_held && !state.bvalid;
    rd_go = s_axi_arvalid && state.arready;
    run = state.run_control[run_bit];
    wr_value = reg_reset;
    mode_new = reg_reset;
    for (int c = 0; c < 2; c++) begin
      dir[c] = state.channel_mode[c*channel_field_step+direction_lsb +: 2];
      ch_is_input[c] = dir[c] != direction_output;
    end
    enable[0] = state.enable_polarity[ch1_enable_bit];
    enable[1] = state.enable_polarity[ch2_enable_bit];
    polarity[0] = state.enable_polarity[ch1_polarity_bit];
    polarity[1] = state.enable_polarity[ch2_polarity_bit];
    comp_polarity[0] = state.enable_polarity[ch1_comp_polarity_bit];
    comp_polarity[1] = state.enable_polarity[ch2_comp_polarity_bit];

    // input stage: three-flop sampling, settled level changes on agreement
    next_state.sync1 = capture_pin;
    next_state.sync2 = state.sync1;
    next_state.sync3 = state.sync2;
    for (int c = 0; c < 2; c++) begin
      if (state.sync2[c] == state.sync3[c]) begin
        next_state.settled[c] = state.sync3[c];
      end
    end
    rise = next_state.settled & ~state.settled;
    fall = ~next_state.settled & state.settled;

    // time base: divider, counter, update event
    count_tick = 1'b0;
    update_event = 1'b0;
    if (run && state.reload_limit != reg_reset) begin
      if (state.divider_count >= state.divider_active) begin
        next_state.divider_count = reg_reset;
        count_tick = 1'b1;
      end else begin
        next_state.divider_count = state.divider_count + 16'h0001;
      end
    end
    if (count_tick) begin
      if (state.count >= state.reload_limit) begin
        next_state.count = reg_reset;
        update_event = 1'b1;
      end else begin
        next_state.count = state.count + 16'h0001;
      end
    end
    if (update_event) begin
      next_state.divider_active = state.divider_shadow;
    end

    // per channel capture and compare
    for (int c = 0; c < 2; c++) begin
      source[c] = (dir[c] == direction_other_pin) ? c == 0 : c == 1;
      unique case ({comp_polarity[c], polarity[c]})
        2'b00: edge_hit[c] = source[c] ? rise[1] : rise[0];
        2'b01: edge_hit[c] = source[c] ? fall[1] : fall[0];
        2'b11: edge_hit[c] = source[c] ? rise[1] | fall[1]
                                       : rise[0] | fall[0];
        2'b10: edge_hit[c] = 1'b0;
      endcase
      capture_now[c] = 1'b0;
      if (!enable[c]) begin
        next_state.event_count[c] = 3'h0;
      end else if (ch_is_input[c] && edge_hit[c]) begin
        if (state.event_count[c] >= events_per_capture(
              state.channel_mode[c*channel_field_step+event_div_lsb +: 2])) begin
          next_state.event_count[c] = 3'h0;
          capture_now[c] = 1'b1;
        end else begin
          next_state.event_count[c] = state.event_count[c] + 3'h1;
        end
      end
      if (capture_now[c]) begin
        next_state.compare_shadow[c] = state.count;
      end
      if (!ch_is_input[c] &&
          (!state.channel_mode[c*channel_field_step+preload_bit] ||
           update_event)) begin
        next_state.compare_active[c] = state.compare_shadow[c];
      end
      // output reference from active compare
      unique case (compare_mode_type'(
        state.channel_mode[c*channel_field_step+compare_mode_lsb +: 3]))
        mode_frozen:   next_state.reference[c] = state.reference[c];
        mode_set:      if (state.count == state.compare_active[c])
                         next_state.reference[c] = 1'b1;
        mode_clear:    if (state.count == state.compare_active[c])
                         next_state.reference[c] = 1'b0;
        mode_toggle:   if (state.count == state.compare_active[c])
                         next_state.reference[c] = ~state.reference[c];
        mode_force_lo: next_state.reference[c] = 1'b0;
        mode_force_hi: next_state.reference[c] = 1'b1;
        mode_pwm1:     next_state.reference[c] =
                         state.count < state.compare_active[c];
        mode_pwm2:     next_state.reference[c] =
                         !(state.count < state.compare_active[c]);
      endcase
      if (!ch_is_input[c] && enable[c]) begin
        next_state.pin_out[c] = next_state.reference[c] ^ polarity[c];
        next_state.pin_oe[c] = 1'b1;
      end else begin
        next_state.pin_out[c] = 1'b0;
        next_state.pin_oe[c] = 1'b0;
      end
    end

    // write channel: address and data taken in either order
    if (s_axi_awvalid && state.awready) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
      next_state.awready = 1'b0;
    end
    if (s_axi_wvalid && state.wready) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
      next_state.wready = 1'b0;
    end
    if (wr_go) begin
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = axi_okay;
      unique case (state.aw_addr)
        run_control_addr: begin
          wr_value = merge16(state.run_control, state.w_data, state.w_strb);
          next_state.run_control = wr_value & 16'h0001;
        end
        channel_mode_addr: begin
          mode_new = merge16(state.channel_mode, state.w_data, state.w_strb)
                     & channel_mode_mask;
          for (int c = 0; c < 2; c++) begin
            if (enable[c]) begin
              mode_new[c*channel_field_step+direction_lsb +: 2] = dir[c];
            end
          end
          next_state.channel_mode = mode_new;
        end
        channel_enable_polarity_addr: begin
          wr_value = merge16(state.enable_polarity, state.w_data,
                             state.w_strb);
          next_state.enable_polarity = wr_value & enable_polarity_mask;
        end
        counter_value_addr: begin
          next_state.count = merge16(state.count, state.w_data,
                                     state.w_strb);
        end
        clock_divider_addr: begin
          next_state.divider_shadow = merge16(state.divider_shadow,
                                              state.w_data, state.w_strb);
        end
        reload_limit_addr: begin
          next_state.reload_limit = merge16(state.reload_limit,
                                            state.w_data, state.w_strb);
        end
        channel_one_compare_addr: begin
          if (!ch_is_input[0]) begin
            next_state.compare_shadow[0] = merge16(state.compare_shadow[0],
                                                   state.w_data, state.w_strb);
          end
        end
        channel_two_compare_addr: begin
          if (!ch_is_input[1]) begin
            next_state.compare_shadow[1] = merge16(state.compare_shadow[1],
                                                   state.w_data, state.w_strb);
          end
        end
        default: next_state.bresp = axi_slverr;
      endcase
    end
    // response taken: ready for the next address and data
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
      next_state.awready = 1'b1;
      next_state.wready = 1'b1;
    end

    // read channel
    if (rd_go) begin
      next_state.arready = 1'b0;
      next_state.rvalid = 1'b1;
      next_state.rresp = axi_okay;
      next_state.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        run_control_addr:   next_state.rdata[15:0] = state.run_control;
        channel_mode_addr:  next_state.rdata[15:0] = state.channel_mode;
        channel_enable_polarity_addr:
          next_state.rdata[15:0] = state.enable_polarity;
        counter_value_addr: next_state.rdata[15:0] = state.count;
        clock_divider_addr: next_state.rdata[15:0] = state.divider_shadow;
        reload_limit_addr:  next_state.rdata[15:0] = state.reload_limit;
        channel_one_compare_addr:
          next_state.rdata[15:0] = state.compare_shadow[0];
        channel_two_compare_addr:
          next_state.rdata[15:0] = state.compare_shadow[1];
        default:            next_state.rresp = axi_slverr;
      endcase
    end
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
      next_state.arready = 1'b1;
    end
  end

  // bus ready flags come out of reset high
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
      state.awready <= 1'b1;
      state.wready <= 1'b1;
      state.arready <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from state flip-flops
  assign s_axi_awready = state.awready;
  assign s_axi_wready = state.wready;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_arready = state.arready;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign ch1_output = state.pin_out[0];
  assign ch2_output = state.pin_out[1];
  assign output_drive_enable = state.pin_oe;

endmodule

// >>> testbench/two_channel_timer_compare_core_assertions.sv
// checker on the timer bus handshakes and channel pins
`timescale 1ns/10ps
module timer_core_checker
  import timer_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // channel pins
  input wire logic        ch1_output,
  input wire logic        ch2_output,
  input wire logic [1:0]  output_drive_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_CH1_OFF: assert property (!output_drive_enable[0] |-> !ch1_output)
    else $error("ch1 output high while disabled");
  AST_CH2_OFF: assert property (!output_drive_enable[1] |-> !ch2_output)
    else $error("ch2 output high while disabled");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_R_UPPER: assert property (s_axi_rvalid |-> !(|s_axi_rdata[31:16]))
    else $error("upper read half not zero");
  AST_R_TIME: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_TIME: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_W_BLOCK: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == axi_slverr
    |-> s_axi_rdata == 32'h0)
    else $error("unmapped read data not zero");
endmodule
bind two_channel_timer_compare_core timer_core_checker i_chk (
  .sys_clk(sys_clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .ch1_output(ch1_output), .ch2_output(ch2_output),
  .output_drive_enable(output_drive_enable));

// >>> testbench/capture_source.sv
// external source driving the two capture input pins
`timescale 1ns/10ps
module capture_source (
  // clock
  input  wire logic       sys_clk,
  // pins toward the timer
  output logic      [1:0] capture_pin
);
  initial capture_pin = 2'b00;
  // one pin moves, then holds long enough to pass the synchroniser
  task automatic drive(input int ch, input logic lvl);
    @(posedge sys_clk) capture_pin[ch] <= lvl;
    repeat (10) @(posedge sys_clk);
  endtask
endmodule

// >>> testbench/tb_two_channel_timer_compare_core.sv
// testbench for the two-channel timer core
`timescale 1ns/10ps
module tb_two_channel_timer_compare_core;
  import timer_pkg::*;
  logic        sys_clk, nrst, ch1_output, ch2_output;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, capture_pin, output_drive_enable, rsp;
  int          bad_count, num_checks, cycles;
  two_channel_timer_compare_core i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .capture_pin(capture_pin), .ch1_output(ch1_output),
    .ch2_output(ch2_output), .output_drive_enable(output_drive_enable));
  capture_source i_pins (.sys_clk(sys_clk), .capture_pin(capture_pin));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'h3;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic count_high(input int n, input logic [31:0] exp);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge sys_clk);
      k += (ch1_output === 1'b1);
    end
    check(k, exp);
  endtask
  task automatic t_reset();
    logic [7:0] regs [6];
    regs = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h34, 8'h38};
    foreach (regs[i]) begin
      rdr(regs[i]);
      check(rd, 32'h0);
    end
    rdr(8'h1c);
    check(rd, 32'h0);
    check(rsp, axi_slverr);
    wr(8'h1c, 16'hffff);
    check(rsp, axi_slverr);
    wr(counter_value_addr, 16'h1234);
    rdr(counter_value_addr);
    check(rd, 32'h1234);
    wr(run_control_addr, 16'h0001);
    repeat (20) @(posedge sys_clk);
    rdr(counter_value_addr);
    check(rd, 32'h1234);
    wr(run_control_addr, 16'h0000);
    wr(channel_enable_polarity_addr, 16'hff77);
    rdr(channel_enable_polarity_addr);
    check(rd, 32'h0033);
    wr(channel_enable_polarity_addr, 16'h0000);
  endtask
  task automatic t_outputs();
    logic o;
    wr(channel_mode_addr, 16'h5050);
    for (int ch = 0; ch < 2; ch++) begin
      for (int p = 0; p < 2; p++) begin
        wr(channel_enable_polarity_addr, 16'(1 + 2 * p) << (4 * ch));
        repeat (3) @(posedge sys_clk);
        o = ch ? ch2_output : ch1_output;
        check({o, output_drive_enable[ch]}, {p == 0, 1'b1});
      end
      wr(channel_enable_polarity_addr, 16'h0000);
      repeat (3) @(posedge sys_clk);
      o = ch ? ch2_output : ch1_output;
      check({o, output_drive_enable[ch]}, 2'b00);
    end
  endtask
  task automatic t_pwm();
    wr(channel_mode_addr, 16'h0060);
    wr(reload_limit_addr, 16'h0010);
    wr(channel_one_compare_addr, 16'h0008);
    wr(counter_value_addr, 16'h0006);
    wr(channel_enable_polarity_addr, 16'h0001);
    wr(channel_mode_addr, 16'h0068);
    wr(channel_one_compare_addr, 16'h0004);
    repeat (3) @(posedge sys_clk);
    check(ch1_output, 1'b1);
    wr(run_control_addr, 16'h0001);
    repeat (40) @(posedge sys_clk);
    count_high(17, 4);
    wr(clock_divider_addr, 16'h0001);
    repeat (40) @(posedge sys_clk);
    count_high(34, 8);
    wr(run_control_addr, 16'h0000);
    // long period: no update, so a new divider must not act yet
    wr(reload_limit_addr, 16'h00ff);
    wr(counter_value_addr, 16'h0000);
    wr(clock_divider_addr, 16'h0003);
    wr(run_control_addr, 16'h0001);
    repeat (40) @(posedge sys_clk);
    wr(run_control_addr, 16'h0000);
    rdr(counter_value_addr);
    check(rd >= 32'h10 && rd <= 32'h1e, 1'b1);
    wr(channel_mode_addr, 16'h0060);
    wr(counter_value_addr, 16'h0006);
    repeat (3) @(posedge sys_clk);
    check(ch1_output, 1'b0);
    wr(channel_one_compare_addr, 16'h0008);
    repeat (3) @(posedge sys_clk);
    check(ch1_output, 1'b1);
  endtask
  task automatic t_capture();
    logic [3:0] cfg [7];
    logic [15:0] last, val;
    logic [6:0] cap;
    cfg = '{4'h0, 4'h1, 4'h1, 4'h3, 4'h3, 4'hb, 4'hb};
    cap = 7'b1101100;
    wr(channel_enable_polarity_addr, 16'h0000);
    wr(channel_mode_addr, 16'h0101);
    for (int ch = 0; ch < 2; ch++) begin
      // channel one still holds the compare value written before
      last = ch ? 16'h0000 : 16'h0008;
      for (int i = 0; i < 7; i++) begin
        val = 16'h1000 + 16'(ch * 256 + i);
        wr(channel_enable_polarity_addr, 16'(cfg[i]) << (4 * ch));
        wr(counter_value_addr, val);
        i_pins.drive(ch, i % 2 == 0);
        if (cap[i]) last = val;
        rdr(ch ? channel_two_compare_addr : channel_one_compare_addr);
        check(rd, {16'h0000, last});
      end
    end
    // channel one is off and takes the new direction, channel two keeps it
    wr(channel_mode_addr, 16'h0000);
    rdr(channel_mode_addr);
    check(rd, 32'h0100);
  endtask
  initial begin
    nrst = 1'b0; cycles = 0; bad_count = 0; num_checks = 0;
    s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00; s_axi_wdata = 32'h0; s_axi_wstrb = 4'h0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_outputs();
    t_pwm();
    t_capture();
    finish_test();
  end
endmodule
